// [dor_params.svh]
// register map, field positions, reset values and timing figures of the output stage
`ifndef DOR_PARAMS_SVH
`define DOR_PARAMS_SVH

`define DOR_CLK_HZ          125_000_000
`define DOR_PWM_MAX_HZ      2_000
`define DOR_OUT_MAX_HZ      500
`define DOR_LED_FLASH_HZ    2

`define DOR_ADDR_W          8
`define DOR_OFS_CMD         8'h00
`define DOR_OFS_POL         8'h04
`define DOR_OFS_MAN_EN      8'h08
`define DOR_OFS_MAN_VAL     8'h0C
`define DOR_OFS_APPLIED     8'h10
`define DOR_OFS_ROUTE_EN    8'h14
`define DOR_OFS_LED         8'h18
`define DOR_OFS_SFE         8'h1C
`define DOR_OFS_FAULT_SEL   8'h20
`define DOR_OFS_STATUS      8'h24
`define DOR_OFS_ROUTE_BASE  8'h40

`define DOR_OUT_BIT0        16
`define DOR_BRAKE_BIT       0
`define DOR_INTERLOCK_BIT   3
`define DOR_ROUTE_OFF       16'h0FFF
`define DOR_INV_BIT         7
`define DOR_LED_GREEN_BIT   0
`define DOR_LED_RED_BIT     1
`define DOR_ST_FAULT_BIT    0
`define DOR_ST_MOTION_BIT   1

`define DOR_SRC_ONE         8'h00
`define DOR_SRC_ZERO        8'h01
`define DOR_SRC_ENC_LO      8'h02
`define DOR_SRC_ENC_HI      8'h08
`define DOR_SRC_POS_LO      8'h09
`define DOR_SRC_POS_HI      8'h0F
`define DOR_SRC_PWM         8'h10
`define DOR_SRC_PWM_N       8'h11

`define DOR_RESP_OKAY       2'b00
`define DOR_RESP_SLVERR     2'b10

`endif

// [dor_pkg.sv]
// types and source decoding shared by the digital output stage
package dor_pkg;

    typedef enum logic [2:0] {
        DOR_K_ONE,
        DOR_K_ZERO,
        DOR_K_ENC,
        DOR_K_POS,
        DOR_K_PWM,
        DOR_K_PWM_N,
        DOR_K_BAD
    } dor_kind_t;

    typedef struct packed {
        logic [7:0] src;
        logic       inv;
        logic [6:0] sel;
    } dor_route_t;

    typedef struct packed {
        dor_kind_t  kind;
        logic [2:0] div_log2;
    } dor_src_t;

    function automatic dor_src_t dor_decode(input logic [7:0] code);
        dor_src_t s;
        s.div_log2 = 3'd0;
        if (code == 8'h00) begin
            s.kind = DOR_K_ONE;
        end else if (code == 8'h01) begin
            s.kind = DOR_K_ZERO;
        end else if (code >= 8'h02 && code <= 8'h08) begin
            s.kind     = DOR_K_ENC;
            s.div_log2 = 3'(code - 8'h02);
        end else if (code >= 8'h09 && code <= 8'h0F) begin
            s.kind     = DOR_K_POS;
            s.div_log2 = 3'(code - 8'h09);
        end else if (code == 8'h10) begin
            s.kind = DOR_K_PWM;
        end else if (code == 8'h11) begin
            s.kind = DOR_K_PWM_N;
        end else begin
            s.kind = DOR_K_BAD;
        end
        return s;
    endfunction : dor_decode

endpackage : dor_pkg

// [dor_top.sv]
// digital output stage: command mapping, routing, interlock and LED control
`timescale 1ns/100ps
`include "dor_params.svh"

module dor_top
    import dor_pkg::*;
#(
    parameter int N_OUT    = 2,
    parameter int PWM_HOLD = (`DOR_CLK_HZ + 2 * `DOR_PWM_MAX_HZ - 1) / (2 * `DOR_PWM_MAX_HZ),
    parameter int OUT_HOLD = (`DOR_CLK_HZ + 2 * `DOR_OUT_MAX_HZ - 1) / (2 * `DOR_OUT_MAX_HZ),
    parameter int LED_HALF = `DOR_CLK_HZ / (2 * `DOR_LED_FLASH_HZ)
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [31:0]      input_state_word,
    input  wire logic             enc_step,
    input  wire logic             pos_step,
    input  wire logic             brake_pwm,
    output logic [N_OUT-1:0]      out_pin,
    output logic                  brake_out,
    output logic                  pwm_out,
    output logic                  led_green,
    output logic                  led_red,
    output logic                  motion_enable,
    output logic                  fault_active,
    output logic [31:0]           fault_reaction
);
    localparam int NE = N_OUT + 1;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = val[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // register bus
    logic [31:0]      cmd_reg, pol_reg, man_en_reg, man_val_reg, applied_reg;
    logic [31:0]      sfe_reg, fault_sel_reg;
    logic             route_en_reg;
    logic [1:0]       led_ctl_reg;
    logic             fault_reg;
    logic [15:0]      route_reg [NE];
    logic             aw_hold_reg, w_hold_reg;
    logic [7:0]       aw_addr_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    logic             have_aw, have_w, wr_do, bvalid_next, aw_hold_next, w_hold_next;
    logic [7:0]       wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic             wr_hit, rd_hit, rvalid_next;
    logic [31:0]      rd_data;

    assign have_aw = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
    assign have_w  = w_hold_reg | (s_axi_wvalid & s_axi_wready);
    assign wr_do   = have_aw & have_w;
    assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
    assign aw_hold_next = have_aw & ~wr_do;
    assign w_hold_next  = have_w & ~wr_do;
    assign bvalid_next  = wr_do | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_next  = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

    always_comb begin
        wr_hit = 1'b1;
        unique case (wr_addr)
            `DOR_OFS_CMD, `DOR_OFS_POL, `DOR_OFS_MAN_EN, `DOR_OFS_MAN_VAL, `DOR_OFS_APPLIED,
            `DOR_OFS_ROUTE_EN, `DOR_OFS_LED, `DOR_OFS_SFE, `DOR_OFS_FAULT_SEL,
            `DOR_OFS_STATUS: wr_hit = 1'b1;
            default: wr_hit = (wr_addr >= `DOR_OFS_ROUTE_BASE) && (wr_addr[1:0] == 2'b00)
                              && (32'(wr_addr - `DOR_OFS_ROUTE_BASE) < 32'(4 * NE));
        endcase
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `DOR_OFS_CMD:       rd_data = cmd_reg;
            `DOR_OFS_POL:       rd_data = pol_reg;
            `DOR_OFS_MAN_EN:    rd_data = man_en_reg;
            `DOR_OFS_MAN_VAL:   rd_data = man_val_reg;
            `DOR_OFS_APPLIED:   rd_data = applied_reg;
            `DOR_OFS_ROUTE_EN:  rd_data = {31'h0000_0000, route_en_reg};
            `DOR_OFS_LED:       rd_data = {30'h0000_0000, led_ctl_reg};
            `DOR_OFS_SFE:       rd_data = sfe_reg;
            `DOR_OFS_FAULT_SEL: rd_data = fault_sel_reg;
            `DOR_OFS_STATUS:    rd_data = {30'h0000_0000, motion_enable, fault_reg};
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < NE; i++) begin
                    if (s_axi_araddr == 8'(`DOR_OFS_ROUTE_BASE + 4 * i)) begin
                        rd_data = {16'h0000, route_reg[i]};
                        rd_hit  = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DOR_RESP_OKAY;
        end else begin
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            // no new address or data until the response is taken
            s_axi_awready <= ~aw_hold_next & ~bvalid_next;
            s_axi_wready  <= ~w_hold_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (wr_do) begin
                s_axi_bresp <= wr_hit ? `DOR_RESP_OKAY : `DOR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DOR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_hit ? `DOR_RESP_OKAY : `DOR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_reg       <= 32'h0000_0000;
            pol_reg       <= 32'h0000_0000;
            man_en_reg    <= 32'h0000_0000;
            man_val_reg   <= 32'h0000_0000;
            sfe_reg       <= 32'h0000_0000;
            fault_sel_reg <= 32'h0000_0000;
            route_en_reg  <= 1'b0;
            led_ctl_reg   <= 2'b00;
            for (int i = 0; i < NE; i++) begin
                route_reg[i] <= `DOR_ROUTE_OFF;
            end
        end else if (wr_do) begin
            unique case (wr_addr)
                `DOR_OFS_CMD:       cmd_reg       <= merge(cmd_reg, wr_data, wr_strb);
                `DOR_OFS_POL:       pol_reg       <= merge(pol_reg, wr_data, wr_strb);
                `DOR_OFS_MAN_EN:    man_en_reg    <= merge(man_en_reg, wr_data, wr_strb);
                `DOR_OFS_MAN_VAL:   man_val_reg   <= merge(man_val_reg, wr_data, wr_strb);
                `DOR_OFS_SFE:       sfe_reg       <= merge(sfe_reg, wr_data, wr_strb);
                `DOR_OFS_FAULT_SEL: fault_sel_reg <= merge(fault_sel_reg, wr_data, wr_strb);
                `DOR_OFS_ROUTE_EN: begin
                    if (wr_strb[0]) begin
                        route_en_reg <= wr_data[0];
                    end
                end
                `DOR_OFS_LED: begin
                    if (wr_strb[0]) begin
                        led_ctl_reg <= wr_data[1:0];
                    end
                end
                default: begin
                    for (int i = 0; i < NE; i++) begin
                        if (wr_addr == 8'(`DOR_OFS_ROUTE_BASE + 4 * i)) begin
                            route_reg[i] <= 16'(merge({16'h0000, route_reg[i]}, wr_data,
                                                      wr_strb));
                        end
                    end
                end
            endcase
        end
    end

    // interlock
    logic interlock_trip;
    logic fault_clr;

    assign interlock_trip = sfe_reg[`DOR_INTERLOCK_BIT] & ~input_state_word[`DOR_INTERLOCK_BIT];
    assign fault_clr      = wr_do && wr_addr == `DOR_OFS_STATUS && wr_strb[0]
                            && wr_data[`DOR_ST_FAULT_BIT];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault_reg      <= 1'b0;
            motion_enable  <= 1'b0;
            fault_active   <= 1'b0;
            fault_reaction <= 32'h0000_0000;
        end else begin
            // trip wins over a clear in the same cycle
            fault_reg      <= interlock_trip | (fault_reg & ~fault_clr);
            motion_enable  <= ~interlock_trip & ~fault_reg;
            fault_active   <= interlock_trip | fault_reg;
            fault_reaction <= fault_sel_reg;
        end
    end

    // output routing
    logic [NE-1:0] route_lvl;
    logic [NE-1:0] route_act;

    for (genvar e = 0; e < NE; e++) begin : g_route
        localparam int HOLD = (e == 0) ? PWM_HOLD : OUT_HOLD;
        dor_route_t  ent;
        dor_src_t    src;
        logic        gate, want, is_pulse, step, ev;
        logic [5:0]  step_cnt_reg;
        logic [5:0]  mask;
        logic [31:0] hold_reg;
        logic        lvl_reg;

        assign ent = route_reg[e];
        assign src = dor_decode(ent.src);
        // FFF and unknown sources fall back to plain mapping on the outputs, entry 0 holds the pwm pin low
        assign route_act[e] = route_en_reg && route_reg[e] != `DOR_ROUTE_OFF
                              && src.kind != DOR_K_BAD;
        // gate bit picked by bits 6:0, none at 32 and above
        // bit 7 inverts the gate sense
        assign gate = (ent.sel < 7'd32) && (cmd_reg[ent.sel[4:0]] ^ ent.inv);
        assign is_pulse = src.kind == DOR_K_ENC || src.kind == DOR_K_POS;
        assign step = (src.kind == DOR_K_ENC) ? enc_step : pos_step;
        assign mask = 6'((7'd1 << src.div_log2) - 7'd1);
        // event on the last step of each 2^k group
        // mask 0 gives one event per increment
        assign ev = is_pulse && step && ((step_cnt_reg & mask) == mask);

        always_comb begin
            unique case (src.kind)
                DOR_K_ONE:   want = gate;
                DOR_K_ZERO:  want = 1'b0;
                DOR_K_PWM:   want = gate & brake_pwm;
                DOR_K_PWM_N: want = gate & ~brake_pwm;
                default:     want = 1'b0;
            endcase
        end

        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                step_cnt_reg <= 6'd0;
            end else if (is_pulse && step) begin
                step_cnt_reg <= step_cnt_reg + 6'd1;
            end
        end

        // each level held at least half the top rate's period
        // limitation: events that land inside a held pulse are dropped
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                hold_reg <= 32'd0;
                lvl_reg  <= 1'b0;
            end else if (hold_reg != 32'd0) begin
                hold_reg <= hold_reg - 32'd1;
            end else if (is_pulse) begin
                if (lvl_reg || (ev && gate && route_act[e])) begin
                    lvl_reg  <= ~lvl_reg;
                    hold_reg <= 32'(HOLD - 1);
                end
            end else if ((want && route_act[e]) != lvl_reg) begin
                lvl_reg  <= want && route_act[e];
                hold_reg <= 32'(HOLD - 1);
            end
        end
        assign route_lvl[e] = lvl_reg;
    end

    // pins
    logic [31:0] base, drive;

    always_comb begin
        base = cmd_reg;
        for (int i = 0; i < N_OUT; i++) begin
            if (route_act[i+1]) begin
                base[`DOR_OUT_BIT0 + i] = route_lvl[i+1];
            end
        end
        // manual value replaces it, brake included
        drive = (man_en_reg & man_val_reg) | (~man_en_reg & (base ^ pol_reg));
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_pin     <= '0;
            brake_out   <= 1'b0;
            pwm_out     <= 1'b0;
            applied_reg <= 32'h0000_0000;
        end else begin
            out_pin     <= drive[`DOR_OUT_BIT0 +: N_OUT];
            // brake from bit 0, other low bits unused
            brake_out   <= drive[`DOR_BRAKE_BIT];
            // entry 0 is the software pwm pin
            pwm_out     <= route_act[0] & route_lvl[0];
            applied_reg <= 32'(drive[`DOR_OUT_BIT0 +: N_OUT]) << `DOR_OUT_BIT0
                           | {31'h0000_0000, drive[`DOR_BRAKE_BIT]};
        end
    end

    // status LEDs
    logic [31:0] led_cnt_reg;
    logic        blink_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            led_cnt_reg <= 32'd0;
            blink_reg   <= 1'b0;
        end else if (led_cnt_reg == 32'(LED_HALF - 1)) begin
            led_cnt_reg <= 32'd0;
            blink_reg   <= ~blink_reg;
        end else begin
            led_cnt_reg <= led_cnt_reg + 32'd1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            led_green <= 1'b0;
            led_red   <= 1'b0;
        end else begin
            // green flashes when healthy, red flashes on error
            led_green <= led_ctl_reg[`DOR_LED_GREEN_BIT] & ~fault_reg & blink_reg;
            led_red   <= led_ctl_reg[`DOR_LED_RED_BIT] & fault_reg & blink_reg;
        end
    end

    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic brake_cmd, man0_on, man0_val;
    assign brake_cmd = cmd_reg[0] ^ pol_reg[0];
    assign man0_on   = man_en_reg[`DOR_OUT_BIT0];
    assign man0_val  = man_val_reg[`DOR_OUT_BIT0];

    sequence s_trip;
        interlock_trip;
    endsequence
    sequence s_faulted;
        fault_reg && !motion_enable;
    endsequence

    a_interlock_trip: assert property (s_trip |=> s_faulted)
        else $error("interlock low did not stop motion");
    a_interlock_gated: assert property (!sfe_reg[3] && !fault_reg |=> !fault_reg)
        else $error("fault set with interlock disabled");
    a_brake_map: assert property (!man_en_reg[0] |=> brake_out == $past(brake_cmd))
        else $error("brake level does not follow command and polarity");
    a_manual_wins: assert property (man0_on |=> out_pin[0] == $past(man0_val))
        else $error("manual value not applied to output 1");
    a_applied_mirror: assert property (applied_reg[`DOR_OUT_BIT0 +: N_OUT] == out_pin
                                       && applied_reg[0] == brake_out)
        else $error("applied readback differs from pins");
    a_route_off_pwm: assert property (!route_en_reg |=> !pwm_out)
        else $error("pwm pin active with routing off");
    a_led_off: assert property (!led_ctl_reg[0] |=> !led_green)
        else $error("green led on while disabled");
    a_unrouted_out: assert property (!route_en_reg && !man0_on && !pol_reg[16]
                                     |=> out_pin[0] == $past(cmd_reg[16]))
        else $error("output 1 not driven from command bit 16");
    a_pulse_hold: assert property ($rose(g_route[1].lvl_reg) |=> g_route[1].lvl_reg [*8])
        else $error("routed level changed too soon");
    a_write_resp: assert property (wr_do |=> s_axi_bvalid)
        else $error("write response missing");

endmodule : dor_top

// [dor_load_model.sv]
// load side: step sources, brake PWM and edge counter on output 1
`timescale 1ns/100ps
module dor_load_model (
    input  wire logic mclk,
    input  wire logic step_go,
    input  wire logic out_lvl,
    output logic      enc_step,
    output logic      pos_step,
    output logic      brake_pwm,
    output int        rise_cnt
);
    logic [4:0] ph_reg  = 5'h00;
    logic       lvl_reg = 1'b0;
    int         cnt_reg = 0;
    // steps 32 cycles apart, so a held pulse never swallows the next one
    assign enc_step  = step_go && ph_reg == 5'h00;
    assign pos_step  = enc_step;
    assign brake_pwm = ph_reg[4];
    assign rise_cnt  = cnt_reg;
    always_ff @(posedge mclk) begin
        ph_reg  <= ph_reg + 5'h01;
        lvl_reg <= out_lvl;
        if (out_lvl && !lvl_reg) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule : dor_load_model

// [tb_digital_output_routing.sv]
// bench for the output stage: bus, pin mapping, routing, interlock, LEDs
`timescale 1ns/100ps
`include "dor_params.svh"
module tb_digital_output_routing;
    logic        mclk, rst_b, awv, wv, br, arv, rr, go, awr, wrd, bv, arr, rv;
    logic        enc, pos, pwm, brk, pwmo, ledg, ledr, mot, flt;
    logic [1:0]  pins, bresp, rresp, rsp;
    logic [2:0]  seen;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, rdv, isw, frx;
    int          rises, bad_count, compares;
    logic [15:0] ent [6] = '{16'h0005, 16'h0005, 16'h0005, 16'h0085, 16'h0185, 16'h0fff};
    logic [31:0] cmdv [6] = '{32'h0000_0020, 32'h0000_0020, 32'h0001_0000,
                              32'h0000_0000, 32'h0000_0000, 32'h0001_0020};
    logic [5:0]  expv = 6'h2a;
    dor_top #(.N_OUT(2), .PWM_HOLD(10), .OUT_HOLD(10), .LED_HALF(4)) uut (
        .mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .input_state_word(isw), .enc_step(enc), .pos_step(pos), .brake_pwm(pwm),
        .out_pin(pins), .brake_out(brk), .pwm_out(pwmo), .led_green(ledg),
        .led_red(ledr), .motion_enable(mot), .fault_active(flt), .fault_reaction(frx));
    dor_load_model lm (.mclk(mclk), .step_go(go), .out_lvl(pins[0]), .enc_step(enc),
        .pos_step(pos), .brake_pwm(pwm), .rise_cnt(rises));
    always #4 mclk = ~mclk;
    task automatic results;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // one task for both directions keeps read and write handshakes identical
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        awa <= a;
        ara <= a;
        wd  <= d;
        {awv, wv, br, arv, rr} <= {w, w, w, !w, !w};
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            if ((bv && br) || (rv && rr)) break;
        end
        rdv = rd;
        rsp = w ? bresp : rresp;
        {br, rr} <= 2'b00;
        if (n == 50) begin
            chk(32'h0, 32'h1, "bus timeout");
            results();
        end
    endtask : bus
    function automatic logic [31:0] pin_exp(input logic [31:0] c, p, e, v);
        return ((e & v) | (~e & (c ^ p))) & 32'h0003_0001;
    endfunction : pin_exp
    task automatic led_scan(input logic red);
        seen = 3'h0;
        repeat (16) begin
            @(posedge mclk);
            seen = seen | (red ? {ledg, ledr, !ledr} : {ledr, ledg, !ledg});
        end
    endtask : led_scan
    initial begin
        logic [31:0] c, p, e, x;
        int          k, n0;
        {mclk, rst_b, awv, wv, br, arv, rr, go} = '0;
        {awa, ara, wd} = '0;
        isw = 32'h0000_0008;
        void'($urandom(32'hcce1));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        bus(0, 8'h44, 0);
        chk(rdv, 32'h0000_0fff, "entry reset");
        repeat (6) begin
            c = $urandom;
            p = $urandom;
            e = $urandom & $urandom;
            x = $urandom;
            bus(1, `DOR_OFS_CMD, c);
            bus(1, `DOR_OFS_POL, p);
            bus(1, `DOR_OFS_MAN_EN, e);
            bus(1, `DOR_OFS_MAN_VAL, x);
            x = pin_exp(c, p, e, x);
            repeat (2) @(posedge mclk);
            chk(32'({pins, brk}), {29'h0, x[17:16], x[0]}, "pins");
            bus(0, `DOR_OFS_APPLIED, 0);
            chk(rdv, x, "applied");
        end
        bus(1, `DOR_OFS_POL, 0);
        bus(1, `DOR_OFS_MAN_EN, 0);
        bus(0, 8'h30, 0);
        chk(32'(rsp), 32'(`DOR_RESP_SLVERR), "unmapped");
        bus(1, 8'h30, 0);
        chk(32'(rsp), 32'(`DOR_RESP_SLVERR), "unmapped write");
        for (k = 0; k < 6; k++) begin
            bus(1, `DOR_OFS_ROUTE_EN, 32'(k != 0));
            bus(1, 8'h44, {16'h0000, ent[k]});
            bus(1, `DOR_OFS_CMD, cmdv[k]);
            repeat (2) @(posedge mclk);
            chk(32'(pins[0]), 32'(expv[k]), "routed level");
        end
        bus(1, 8'h40, 32'h0000_0005);
        repeat (2) @(posedge mclk);
        chk(32'(pwmo), 32'h1, "pwm entry");
        for (k = 0; k < 8; k++) begin
            bus(1, 8'h44, {16'h0000, 8'(k < 4 ? 2 + k : 5 + k), 8'h05});
            n0 = rises;
            go <= 1'b1;
            repeat (256) @(posedge mclk);
            go <= 1'b0;
            repeat (40) @(posedge mclk);
            chk(32'(rises - n0), 32'(8 >> (k % 4)), "pulse count");
        end
        // pin lags brake pwm by two edges once the hold has caught up
        for (k = 0; k < 2; k++) begin
            bus(1, 8'h44, {16'h0000, 8'(8'h10 + k), 8'h05});
            repeat (48) @(posedge mclk);
            for (n0 = 0; n0 < 64; n0++) begin
                @(posedge mclk);
                if (n0 > 1) chk(32'(pins[0]), 32'(seen[1] ^ k[0]), "brake pwm route");
                seen = {seen[1:0], pwm};
            end
        end
        bus(1, `DOR_OFS_LED, 32'h0000_0003);
        led_scan(0);
        chk(32'(seen), 32'h3, "green flash");
        isw <= 32'h0;
        repeat (3) @(posedge mclk);
        chk(32'({flt, mot}), 32'h1, "interlock off");
        bus(1, `DOR_OFS_SFE, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk(32'({flt, mot}), 32'h2, "interlock trip");
        led_scan(1);
        chk(32'(seen), 32'h3, "red flash");
        c = $urandom;
        bus(1, `DOR_OFS_FAULT_SEL, c);
        repeat (2) @(posedge mclk);
        chk(frx, c, "fault reaction");
        isw <= 32'h8;
        bus(1, `DOR_OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk(32'({flt, mot}), 32'h1, "fault clear");
        results();
    end
endmodule : tb_digital_output_routing
